// ==== core/awu_pkg.sv ====
// Constants, register map and bus types of the auto wakeup timer
package awu_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] PORT_OFS   = 8'h00;
   localparam logic [7:0] KBEN_OFS   = 8'h04;
   localparam logic [7:0] KBSC_OFS   = 8'h08;
   localparam logic [7:0] CFG1_OFS   = 8'h0C;
   localparam logic [7:0] CFG2_OFS   = 8'h10;
   localparam logic [7:0] STAT_OFS   = 8'h14;
   localparam logic [7:0] CLR_OFS    = 8'h18;
   localparam logic [7:0] IEN_OFS    = 8'h1C;
   // ==========================================================
   // Field positions
   localparam int LATCH_BIT  = 6;
   localparam int WEN_BIT    = 6;
   localparam int MASK_BIT   = 1;
   localparam int ACK_BIT    = 2;
   localparam int RATE_BIT   = 0;
   localparam int OSC_BIT    = 1;
   localparam int EV_TMO     = 0;
   localparam int EV_STOP    = 1;
   // ==========================================================
   // Reset values and timeouts in doubled bus clock ticks
   localparam logic [7:0]  REG_RST   = 8'h00;
   localparam logic [1:0]  EV_RST    = 2'h0;
   localparam logic [15:0] TMO_SHORT = 16'h0100;
   localparam logic [15:0] TMO_LONG  = 16'h0800;
   // ==========================================================
   // Bus carriers
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } awu_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } awu_apb_rsp_t;
endpackage : awu_pkg

// ==== core/awu_top.sv ====
// Auto wakeup timer with APB register file and interrupt
`timescale 1ns/10ps
module awu_top
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire awu_pkg::awu_apb_req_t i_apb,
   input  wire logic                  i_stop_mode,
   input  wire logic                  i_wait_mode,
   input  wire logic                  i_dbl_clk_en,
   output awu_pkg::awu_apb_rsp_t      o_apb,
   output logic                       o_stop_wake,
   output logic                       o_irq
);
   import awu_pkg::*;

   // ==========================================================
   // Registers
   logic [7:0]  port_reg;
   logic [7:0]  kben_reg;
   logic [7:0]  kbsc_reg;
   logic [7:0]  cfg1_reg;
   logic [7:0]  cfg2_reg;
   logic [1:0]  stat_reg;
   logic [1:0]  ien_reg;
   logic        latch_reg;
   logic [15:0] cnt_reg;
   logic        stop_q_reg;

   logic        wr_en;
   logic        setup;
   logic        entry;
   logic        wen;
   logic        osc_on;
   logic        run;
   logic        hit;
   logic        ack;
   logic [15:0] tmo;
   logic [31:0] rd_next;
   logic        err_next;

   assign setup  = i_apb.psel & ~i_apb.penable;
   assign wr_en  = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite;
   assign entry  = i_stop_mode & ~stop_q_reg;
   assign wen    = kben_reg[WEN_BIT];
   assign osc_on = cfg2_reg[OSC_BIT];
   assign ack    = wr_en && i_apb.paddr == KBSC_OFS && i_apb.pwdata[ACK_BIT];
   assign tmo    = cfg1_reg[RATE_BIT] ? TMO_LONG : TMO_SHORT;
   // Counts only in stop, never in wait, on the doubled bus clock
   assign run    = i_stop_mode & ~i_wait_mode & wen & osc_on & i_dbl_clk_en;
   assign hit    = run & ~entry & (cnt_reg == tmo - 16'h0001);

   // ==========================================================
   // APB read mux and response
   always_comb
   begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      unique case (i_apb.paddr)
         PORT_OFS: rd_next = {24'h00_0000, port_reg[7], latch_reg, port_reg[5:0]};
         KBEN_OFS: rd_next = {24'h00_0000, kben_reg};
         KBSC_OFS: rd_next = {24'h00_0000, kbsc_reg};
         CFG1_OFS: rd_next = {24'h00_0000, cfg1_reg};
         CFG2_OFS: rd_next = {24'h00_0000, cfg2_reg};
         STAT_OFS: rd_next = {30'h0000_0000, stat_reg};
         CLR_OFS:  rd_next = 32'h0000_0000;
         IEN_OFS:  rd_next = {30'h0000_0000, ien_reg};
         default:  err_next = 1'b1;
      endcase
   end

   // One wait-free access phase after each setup cycle
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_apb <= '0;
      end
      else
      begin
         o_apb.pready  <= setup;
         o_apb.prdata  <= setup ? rd_next : 32'h0000_0000;
         o_apb.pslverr <= setup & err_next;
      end
   end

   // ==========================================================
   // Shared control registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         port_reg <= REG_RST;
         kben_reg <= REG_RST;
         kbsc_reg <= REG_RST;
         cfg1_reg <= REG_RST;
         cfg2_reg <= REG_RST;
         ien_reg  <= EV_RST;
      end
      else if (wr_en)
      begin
         unique case (i_apb.paddr)
            // Bit 6 is not stored: it is the latch
            PORT_OFS: port_reg <= {i_apb.pwdata[7], 1'b0, i_apb.pwdata[5:0]};
            KBEN_OFS: kben_reg <= i_apb.pwdata[7:0];
            KBSC_OFS: kbsc_reg <= {i_apb.pwdata[7:3], 1'b0, i_apb.pwdata[1:0]};
            CFG1_OFS: cfg1_reg <= i_apb.pwdata[7:0];
            CFG2_OFS: cfg2_reg <= i_apb.pwdata[7:0];
            IEN_OFS:  ien_reg  <= i_apb.pwdata[1:0];
            default:  ien_reg  <= ien_reg;
         endcase
      end
   end

   // ==========================================================
   // Stop entry detect and wakeup counter
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stop_q_reg <= 1'b0;
      end
      else
      begin
         stop_q_reg <= i_stop_mode;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_reg <= 16'h0000;
      end
      else if (entry)
      begin
         cnt_reg <= 16'h0000;
      end
      else if (hit)
      begin
         cnt_reg <= 16'h0000;
      end
      else if (run)
      begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Request latch: set by the timer only, set wins over ack
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         latch_reg <= 1'b0;
      end
      else if (hit)
      begin
         latch_reg <= 1'b1;
      end
      else if (ack)
      begin
         latch_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt status, clear and outputs
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stat_reg <= EV_RST;
      end
      else
      begin
         stat_reg[EV_TMO]  <= hit | (stat_reg[EV_TMO] &
            ~(wr_en && i_apb.paddr == CLR_OFS && i_apb.pwdata[EV_TMO]));
         stat_reg[EV_STOP] <= entry | (stat_reg[EV_STOP] &
            ~(wr_en && i_apb.paddr == CLR_OFS && i_apb.pwdata[EV_STOP]));
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_irq       <= 1'b0;
         o_stop_wake <= 1'b0;
      end
      else
      begin
         o_irq       <= |(stat_reg & ien_reg);
         o_stop_wake <= latch_reg & ~kbsc_reg[MASK_BIT];
      end
   end

   // ==========================================================
   // Check-only tick count, kept apart from the timer
   logic [15:0] ref_ticks_reg;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ref_ticks_reg <= 16'h0000;
      end
      else if (entry || hit)
      begin
         ref_ticks_reg <= 16'h0000;
      end
      else if (run)
      begin
         ref_ticks_reg <= ref_ticks_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   wait_idle_a: assert property (i_wait_mode && !entry |=> $stable(cnt_reg))
      else $error("counter moved in wait mode");
   auto_run_a: assert property (run && !entry && !hit |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not advance in stop");
   mask_gate_a: assert property (kbsc_reg[MASK_BIT] ##1 kbsc_reg[MASK_BIT] |-> !o_stop_wake)
      else $error("masked wakeup left stop");
   entry_zero_a: assert property ($rose(i_stop_mode) |=> cnt_reg == 16'h0000)
      else $error("counter not cleared on stop entry");
   latch_read_a: assert property (setup && i_apb.paddr == PORT_OFS
      |=> o_apb.prdata[LATCH_BIT] == $past(latch_reg))
      else $error("port bit 6 does not show latch");
   no_set_a: assert property (!wen |=> !$rose(latch_reg))
      else $error("latch set while disabled");
   osc_gate_a: assert property (!osc_on && !entry |=> $stable(cnt_reg))
      else $error("counter ran with oscillator off");
   rate_sel_a: assert property (hit |-> cnt_reg == (cfg1_reg[RATE_BIT] ?
      TMO_LONG : TMO_SHORT) - 16'h0001)
      else $error("timeout not at selected period");
   tmo_set_a: assert property (hit |=> latch_reg && stat_reg[EV_TMO] ##1 o_irq || !ien_reg[EV_TMO])
      else $error("timeout did not latch request");
   irq_lvl_a: assert property (|(stat_reg & ien_reg) |=> o_irq)
      else $error("enabled status without interrupt");

   // Bus answer checks
   rdy_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("pready held for two cycles");
   rdy_setup_a: assert property (setup |=> o_apb.pready)
      else $error("no answer after setup");
   rd_quiet_a: assert property (!o_apb.pready |-> o_apb.prdata == 32'h0000_0000)
      else $error("read data outside access");
   err_quiet_a: assert property (!o_apb.pready |-> !o_apb.pslverr)
      else $error("error flag outside access");
   err_map_a: assert property (setup && i_apb.paddr == 8'h40 |=> o_apb.pslverr)
      else $error("unmapped address not refused");
   ok_map_a: assert property (setup && i_apb.paddr == PORT_OFS |=> !o_apb.pslverr)
      else $error("mapped address refused");

   // Register and latch checks
   port_bit6_a: assert property (!port_reg[LATCH_BIT])
      else $error("port bit 6 holds storage");
   port_wr_a: assert property (wr_en && i_apb.paddr == PORT_OFS |=> port_reg[5:0] == $past(i_apb.pwdata[5:0]))
      else $error("port data bits not stored");
   wen_read_a: assert property (setup && i_apb.paddr == KBEN_OFS |=> o_apb.prdata[WEN_BIT] == $past(wen))
      else $error("wakeup enable does not read back");
   wen_wr_a: assert property (wr_en && i_apb.paddr == KBEN_OFS |=> wen == $past(i_apb.pwdata[WEN_BIT]))
      else $error("wakeup enable not written");
   ack_read_a: assert property (setup && i_apb.paddr == KBSC_OFS |=> !o_apb.prdata[ACK_BIT])
      else $error("ack bit reads as one");
   ack_clr_a: assert property (ack && !hit |=> !latch_reg)
      else $error("ack did not clear latch");
   set_wins_a: assert property (hit && ack |=> latch_reg)
      else $error("ack beat a timeout");
   latch_hold_a: assert property (!hit && !ack |=> $stable(latch_reg))
      else $error("latch moved without timer or ack");
   wake_up_a: assert property (latch_reg && !kbsc_reg[MASK_BIT] |=> o_stop_wake)
      else $error("unmasked request did not wake");

   // Counter, interrupt and config readback checks
   ref_match_a: assert property (ref_ticks_reg == cnt_reg)
      else $error("counter differs from tick count");
   idle_hold_a: assert property (!i_stop_mode |=> $stable(cnt_reg))
      else $error("counter moved outside stop");
   tick_need_a: assert property (!i_dbl_clk_en && !entry |=> $stable(cnt_reg))
      else $error("counter moved without a tick");
   stop_stat_a: assert property (entry |=> stat_reg[EV_STOP])
      else $error("stop entry not recorded");
   stat_clr_a: assert property (wr_en && i_apb.paddr == CLR_OFS && i_apb.pwdata[EV_TMO] && !hit |=> !stat_reg[EV_TMO])
      else $error("timeout status not cleared");
   irq_off_a: assert property (!(|(stat_reg & ien_reg)) |=> !o_irq)
      else $error("interrupt without enabled status");
   osc_read_a: assert property (setup && i_apb.paddr == CFG2_OFS |=> o_apb.prdata[OSC_BIT] == $past(osc_on))
      else $error("oscillator bit does not read back");
   rate_read_a: assert property (setup && i_apb.paddr == CFG1_OFS |=> o_apb.prdata[RATE_BIT] == $past(cfg1_reg[RATE_BIT]))
      else $error("rate bit does not read back");

   tmo_c:  cover property (hit ##[1:4] o_stop_wake);
   ack_c:  cover property (latch_reg ##1 ack ##1 !latch_reg);
   race_c: cover property (hit && ack);
   err_c:  cover property (o_apb.pready && o_apb.pslverr);
   wait_c: cover property (i_wait_mode && i_stop_mode);
endmodule : awu_top

// ==== tb/awu_host_model.sv ====
// Stop-mode controller and doubled clock model
`timescale 1ns/10ps
module awu_host_model
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_stop_req,
   input  wire logic i_stop_wake,
   output logic      o_stop_mode,
   output logic      o_dbl_clk_en
);
   logic awake_reg;
   // ====
   // Leaves stop on wake until stop is requested anew
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         awake_reg   <= 1'b0;
         o_stop_mode <= 1'b0;
      end
      else
      begin
         awake_reg   <= i_stop_req & (awake_reg | i_stop_wake);
         o_stop_mode <= i_stop_req & ~awake_reg & ~i_stop_wake;
      end
   end
   // ====
   // Doubled clock edge every second cycle
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_dbl_clk_en <= 1'b0;
      else
         o_dbl_clk_en <= ~o_dbl_clk_en;
   end
endmodule : awu_host_model

// ==== tb/auto_wakeup_timer_bench.sv ====
// Self-checking bench of the wakeup timer
`timescale 1ns/10ps
module auto_wakeup_timer_bench;
   import awu_pkg::*;
   logic         i_clk;
   logic         i_rst_n;
   logic         stop_req;
   logic         wait_req;
   logic         stop_mode;
   logic         dbl_en;
   logic         stop_wake;
   logic         irq;
   awu_apb_req_t req;
   awu_apb_rsp_t rsp;
   logic [31:0]  rdat;
   logic         err;
   int           n_errors;
   int           compares;
   int           cyc;
   localparam logic [31:0] P_OFF = 32'hBF;
   localparam logic [31:0] P_ON  = 32'hFF;
   // ====
   // Design and partner
   awu_top awu_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(req),
      .i_stop_mode(stop_mode), .i_wait_mode(wait_req), .i_dbl_clk_en(dbl_en),
      .o_apb(rsp), .o_stop_wake(stop_wake), .o_irq(irq));
   awu_host_model awu_host_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_stop_req(stop_req), .i_stop_wake(stop_wake), .o_stop_mode(stop_mode),
      .o_dbl_clk_en(dbl_en));
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   // ====
   // Bus and compare helpers
   task print_verdict();
      if (n_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      req.penable <= 1'b1;
      do @(posedge i_clk); while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      err  = rsp.pslverr;
      req <= '0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rchk
   task idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask : idle
   // ====
   // Scenarios
   task t_regs();
      rchk(KBEN_OFS, 32'h0);
      wr(KBEN_OFS, 32'h3F);
      rchk(KBEN_OFS, 32'h3F);
      wr(PORT_OFS, 32'hFF);
      rchk(PORT_OFS, P_OFF);
      rchk(8'h40, 32'h0);
      chk1(err, 1'b1);
   endtask : t_regs
   task t_wake();
      wr(KBEN_OFS, 32'h7F);
      wr(CFG2_OFS, 32'h02);
      wr(IEN_OFS, 32'h01);
      stop_req <= 1'b1;
      idle(500);
      rchk(PORT_OFS, P_OFF);
      idle(40);
      rchk(PORT_OFS, P_ON);
      chk1(irq, 1'b1);
      chk1(stop_mode, 1'b0);
      stop_req <= 1'b0;
      wr(KBSC_OFS, 32'h04);
      wr(CLR_OFS, 32'h03);
      rchk(PORT_OFS, P_OFF);
      chk1(irq, 1'b0);
   endtask : t_wake
   task t_restart();
      wr(KBSC_OFS, 32'h02);
      stop_req <= 1'b1;
      idle(300);
      stop_req <= 1'b0;
      idle(5);
      stop_req <= 1'b1;
      idle(300);
      rchk(PORT_OFS, P_OFF);
      idle(240);
      rchk(PORT_OFS, P_ON);
      chk1(stop_wake, 1'b0);
      chk1(stop_mode, 1'b1);
      stop_req <= 1'b0;
      wr(KBSC_OFS, 32'h04);
      wr(CLR_OFS, 32'h03);
   endtask : t_restart
   task t_gates();
      for (int i = 0; i < 3; i++)
      begin
         wr(KBEN_OFS, (i == 2) ? 32'h3F : 32'h7F);
         wr(CFG2_OFS, (i == 1) ? 32'h00 : 32'h02);
         wait_req <= (i == 0);
         stop_req <= 1'b1;
         idle(600);
         rchk(PORT_OFS, P_OFF);
         stop_req <= 1'b0;
         wait_req <= 1'b0;
      end
   endtask : t_gates
   task t_rate1();
      wr(KBEN_OFS, 32'h7F);
      wr(CFG2_OFS, 32'h02);
      wr(CFG1_OFS, 32'h01);
      wr(IEN_OFS, 32'h00);
      stop_req <= 1'b1;
      idle(4080);
      rchk(PORT_OFS, P_OFF);
      idle(60);
      rchk(PORT_OFS, P_ON);
      chk1(irq, 1'b0);
      rchk(STAT_OFS, 32'h03);
      wr(IEN_OFS, 32'h02);
      idle(2);
      chk1(irq, 1'b1);
      stop_req <= 1'b0;
      wr(KBSC_OFS, 32'h04);
      wr(CLR_OFS, 32'h03);
      rchk(STAT_OFS, 32'h00);
      chk1(irq, 1'b0);
   endtask : t_rate1
   initial
   begin
      i_rst_n  = 1'b0;
      req      = '0;
      stop_req = 1'b0;
      wait_req = 1'b0;
      n_errors = 0;
      compares = 0;
      cyc      = 0;
      idle(3);
      i_rst_n <= 1'b1;
      t_regs();
      t_wake();
      t_restart();
      t_gates();
      t_rate1();
      print_verdict();
   end
endmodule : auto_wakeup_timer_bench
